// *** hw/sslp_top.sv ***
/*
 sslp_top: strap capture at reset release and the package
 low-power state sequencer (halt, extended halt, stop-grant,
 extended stop-grant, snoop states), with an axi4-lite window.
 assumes all inputs synchronous to aclk; the system holds the
 strap levels through the first edge after reset release.
*/
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module sslp_top (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// strap pins
	input wire logic system_mgmt_interrupt_n,
	input wire logic strap_self_test_select_n,
	input wire logic strap_no_bus_parking_n,
	input wire logic bus_request_zero_n,
	output sslp_pkg::sslp_strap_t strap_cfg,
	output logic core_init,
	// break events
	input wire logic init_request_n,
	input wire logic [1:0] local_interrupt_lines,
	output logic [3:0] event_service,
	// cores
	input wire logic [1:0] core_halt_exec,
	output logic [1:0] core_halted,
	output logic [1:0] core_disabled,
	// stop clock and mode enables
	input wire logic stop_clock_request_n,
	input wire logic ext_halt_en,
	input wire logic ext_grant_en,
	// bus side
	output logic grant_ack_req,
	input wire logic grant_ack_resp,
	input wire logic snoop_start,
	input wire logic snoop_done,
	output logic snoop_state,
	// operating point
	input wire logic [6:0] vid_nominal,
	input wire logic [6:0] vid_low,
	output logic core_ratio_low,
	output logic [6:0] voltage_id_code,
	output sslp_pkg::sslp_state_t power_state
);
	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	sslp_pkg::sslp_state_t state_q;
	sslp_pkg::sslp_state_t state_d;
	sslp_pkg::sslp_strap_t strap_q;
	logic in_reset_q;
	logic init_q;
	logic [3:0] ev_lvl_q;
	logic [3:0] pend_q;
	logic [3:0] serve_q;
	logic [1:0] halted_q;
	logic [1:0] dis_q;
	logic ext_kind_grant_q;
	logic ext_kind_grant_d;
	logic ret_halt_q;
	logic ret_halt_d;
	logic ratio_low_q;
	logic ratio_low_d;
	logic vid_low_q;
	logic vid_low_d;
	logic [6:0] vid_q;
	logic [sslp_pkg::CNT_W-1:0] cnt_q;
	logic [sslp_pkg::CNT_W-1:0] cnt_d;
	logic reg_wr;
	logic [11:0] reg_waddr;
	logic [31:0] reg_wdata;
	logic [3:0] reg_wstrb;
	logic [11:0] reg_raddr;

	function automatic logic [sslp_pkg::CNT_W-1:0] cyc(input int n);
		cyc = sslp_pkg::CNT_W'(n - 1);
	endfunction

	// an unknown state (before the first reset edge) decodes as outside stop-grant
	function automatic logic stop_family(input sslp_pkg::sslp_state_t s, input logic ext_grant);
		case (s)
			sslp_pkg::ST_ACK, sslp_pkg::ST_GRANT_WAIT, sslp_pkg::ST_GRANT,
				sslp_pkg::ST_GRANT_SNOOP: stop_family = 1'b1;
			sslp_pkg::ST_LOW_RATIO, sslp_pkg::ST_LOW_VID, sslp_pkg::ST_EXT,
				sslp_pkg::ST_EXT_SNOOP, sslp_pkg::ST_REST_VID,
				sslp_pkg::ST_REST_RATIO: stop_family = ext_grant;
			default: stop_family = 1'b0;
		endcase
	endfunction

	// ------------------------------------------------------------
	// event detection and decoding
	// ------------------------------------------------------------
	wire stop_req = ~stop_clock_request_n;
	wire [3:0] ev_lvl = {local_interrupt_lines[1], local_interrupt_lines[0],
		~init_request_n, ~system_mgmt_interrupt_n};
	wire [3:0] ev_now = ev_lvl & ~ev_lvl_q;
	wire in_normal = state_q == sslp_pkg::ST_NORMAL;
	wire [3:0] serve_now = in_normal ? (ev_now | pend_q) : 4'h0;
	wire brk = |ev_now | |pend_q;
	wire [1:0] halted_nx = serve_now != 4'h0 ? 2'h0 : (halted_q | core_halt_exec);
	wire all_halted = &(halted_nx | dis_q);
	wire cnt_zero = cnt_q == '0;
	wire grant_family = stop_family(state_q, ext_kind_grant_q);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_zero ? cnt_q : cnt_q - 1'b1;
		ext_kind_grant_d = ext_kind_grant_q;
		ret_halt_d = ret_halt_q;
		ratio_low_d = ratio_low_q;
		vid_low_d = vid_low_q;
		case (state_q)
			sslp_pkg::ST_NORMAL: begin
				if (stop_req) begin
					state_d = sslp_pkg::ST_ACK;
					ret_halt_d = 1'b0;
					ext_kind_grant_d = ext_grant_en;
				end else if (all_halted) begin
					ext_kind_grant_d = 1'b0;
					if (ext_halt_en) begin
						state_d = sslp_pkg::ST_LOW_RATIO;
						ratio_low_d = 1'b1;
						cnt_d = cyc(sslp_pkg::RATIO_SETTLE_CYC);
					end else begin
						state_d = sslp_pkg::ST_HALT;
					end
				end
			end
			sslp_pkg::ST_HALT: begin
				if (brk) begin
					state_d = sslp_pkg::ST_NORMAL;
				end else if (stop_req) begin
					state_d = sslp_pkg::ST_ACK;
					ret_halt_d = 1'b1;
					ext_kind_grant_d = ext_grant_en;
				end else if (snoop_start) begin
					state_d = sslp_pkg::ST_HALT_SNOOP;
				end
			end
			sslp_pkg::ST_HALT_SNOOP: begin
				if (snoop_done) begin
					state_d = sslp_pkg::ST_HALT;
				end
			end
			sslp_pkg::ST_ACK: begin
				if (grant_ack_resp) begin
					state_d = sslp_pkg::ST_GRANT_WAIT;
					cnt_d = cyc(sslp_pkg::GRANT_DELAY_CYC);
				end
			end
			sslp_pkg::ST_GRANT_WAIT: begin
				if (cnt_zero) begin
					if (ext_kind_grant_q) begin
						state_d = sslp_pkg::ST_LOW_RATIO;
						ratio_low_d = 1'b1;
						cnt_d = cyc(sslp_pkg::RATIO_SETTLE_CYC);
					end else begin
						state_d = sslp_pkg::ST_GRANT;
					end
				end
			end
			sslp_pkg::ST_GRANT: begin
				if (!stop_req) begin
					state_d = ret_halt_q ? sslp_pkg::ST_HALT : sslp_pkg::ST_NORMAL;
				end else if (snoop_start) begin
					state_d = sslp_pkg::ST_GRANT_SNOOP;
				end
			end
			sslp_pkg::ST_GRANT_SNOOP: begin
				if (snoop_done) begin
					state_d = sslp_pkg::ST_GRANT;
				end
			end
			sslp_pkg::ST_LOW_RATIO: begin
				if (cnt_zero) begin
					state_d = sslp_pkg::ST_LOW_VID;
					vid_low_d = 1'b1;
					cnt_d = cyc(sslp_pkg::VID_SETTLE_CYC);
				end
			end
			sslp_pkg::ST_LOW_VID: begin
				if (cnt_zero) begin
					state_d = sslp_pkg::ST_EXT;
				end
			end
			sslp_pkg::ST_EXT: begin
				if (ext_kind_grant_q ? !stop_req : (brk || stop_req)) begin
					state_d = sslp_pkg::ST_REST_VID;
					vid_low_d = 1'b0;
					cnt_d = cyc(sslp_pkg::VID_SETTLE_CYC);
				end else if (snoop_start) begin
					state_d = sslp_pkg::ST_EXT_SNOOP;
				end
			end
			sslp_pkg::ST_EXT_SNOOP: begin
				if (snoop_done) begin
					state_d = sslp_pkg::ST_EXT;
				end
			end
			sslp_pkg::ST_REST_VID: begin
				if (cnt_zero) begin
					state_d = sslp_pkg::ST_REST_RATIO;
					ratio_low_d = 1'b0;
					cnt_d = cyc(sslp_pkg::RATIO_SETTLE_CYC);
				end
			end
			sslp_pkg::ST_REST_RATIO: begin
				if (cnt_zero) begin
					state_d = (ext_kind_grant_q && ret_halt_q) ?
						sslp_pkg::ST_HALT : sslp_pkg::ST_NORMAL;
				end
			end
			default: begin
				state_d = sslp_pkg::ST_NORMAL;
			end
		endcase
	end

	// ------------------------------------------------------------
	// state registers
	// ------------------------------------------------------------
	// a reset inside the grant family re-initializes but keeps
	// the package stopped; any other reset lands in normal
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= grant_family ? sslp_pkg::ST_GRANT : sslp_pkg::ST_NORMAL;
			cnt_q <= '0;
			ext_kind_grant_q <= 1'b0;
			ret_halt_q <= 1'b0;
			ratio_low_q <= 1'b0;
			vid_low_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			ext_kind_grant_q <= ext_kind_grant_d;
			ret_halt_q <= ret_halt_d;
			ratio_low_q <= ratio_low_d;
			vid_low_q <= vid_low_d;
		end
	end

	// bus clock is never touched: only the core ratio select and the voltage id code move
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			vid_q <= 7'h00;
		end else begin
			vid_q <= vid_low_d ? vid_low : vid_nominal;
		end
	end

	// ------------------------------------------------------------
	// strap capture
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			in_reset_q <= 1'b1;
			init_q <= 1'b0;
			strap_q <= '0;
		end else begin
			in_reset_q <= 1'b0;
			init_q <= in_reset_q;
			if (in_reset_q) begin
				strap_q.out_tristate <= ~system_mgmt_interrupt_n;
				strap_q.run_self_test <= ~strap_self_test_select_n;
				strap_q.no_bus_parking <= ~strap_no_bus_parking_n;
				strap_q.agent_id <= ~bus_request_zero_n;
			end
		end
	end

	// ------------------------------------------------------------
	// events, pending latch and per-core halt
	// ------------------------------------------------------------
	// the first cycle after release only seeds the level history,
	// so strap levels are not mistaken for interrupts
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ev_lvl_q <= 4'hf;
			pend_q <= 4'h0;
			serve_q <= 4'h0;
			halted_q <= 2'h0;
		end else begin
			ev_lvl_q <= ev_lvl;
			serve_q <= serve_now;
			halted_q <= in_normal ? halted_nx : halted_q;
			if (in_normal) begin
				pend_q <= 4'h0;
			end else begin
				pend_q <= pend_q | ev_now;
			end
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	wire wr_ctrl = reg_waddr == sslp_pkg::CTRL_OFS;
	wire [1:0] dis_wr = reg_wdata[sslp_pkg::CTRL_CORE_DIS_LSB +: 2];
	wire wr_known = wr_ctrl || reg_waddr == sslp_pkg::STATUS_OFS
		|| reg_waddr == sslp_pkg::STRAP_OFS || reg_waddr == sslp_pkg::PEND_OFS;
	wire wr_bad = !wr_known || (wr_ctrl && reg_wstrb[0] && &dis_wr);
	wire [31:0] stat_word = {15'h0000, vid_low_q, ratio_low_q, halted_q, state_q};
	wire rd_ctrl = reg_raddr == sslp_pkg::CTRL_OFS;
	wire rd_stat = reg_raddr == sslp_pkg::STATUS_OFS;
	wire rd_strap = reg_raddr == sslp_pkg::STRAP_OFS;
	wire rd_pend = reg_raddr == sslp_pkg::PEND_OFS;
	wire rd_bad = !(rd_ctrl || rd_stat || rd_strap || rd_pend);
	wire [31:0] rd_word = rd_ctrl ? {30'h0, dis_q}
		: rd_stat ? stat_word
		: rd_strap ? {28'h0, strap_q}
		: rd_pend ? {28'h0, pend_q} : 32'h0000_0000;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dis_q <= sslp_pkg::CTRL_RST;
		end else if (reg_wr && wr_ctrl && reg_wstrb[0] && !wr_bad) begin
			dis_q <= dis_wr;
		end
	end

	sslp_axil_slave u_axil (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.reg_wr(reg_wr),
		.reg_waddr(reg_waddr),
		.reg_wdata(reg_wdata),
		.reg_wstrb(reg_wstrb),
		.reg_werr(wr_bad),
		.reg_raddr(reg_raddr),
		.reg_rdata(rd_word),
		.reg_rerr(rd_bad)
	);

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign strap_cfg = strap_q;
	assign core_init = init_q;
	assign event_service = serve_q;
	assign core_halted = halted_q;
	assign core_disabled = dis_q;
	assign grant_ack_req = state_q == sslp_pkg::ST_ACK;
	assign snoop_state = state_q == sslp_pkg::ST_HALT_SNOOP
		|| state_q == sslp_pkg::ST_GRANT_SNOOP
		|| state_q == sslp_pkg::ST_EXT_SNOOP;
	assign core_ratio_low = ratio_low_q;
	assign voltage_id_code = vid_q;
	assign power_state = state_q;
endmodule

// *** hw/sslp_pkg.sv ***
/*
 sslp_pkg: shared constants, state codes and carrier types
 for the strap capture and low-power sequencer.
 assumes a 125 MHz bus clock.
*/
package sslp_pkg;
	localparam int CLK_MHZ = 125;
	localparam int GRANT_DELAY_CYC = 20;
	localparam int RATIO_SETTLE_NS = 1000;
	localparam int VID_SETTLE_NS = 2000;
	localparam int RATIO_SETTLE_CYC = (RATIO_SETTLE_NS * CLK_MHZ + 999) / 1000;
	localparam int VID_SETTLE_CYC = (VID_SETTLE_NS * CLK_MHZ + 999) / 1000;
	localparam int CNT_W = 9;

	// register map
	localparam logic [11:0] CTRL_OFS = 12'h000;
	localparam logic [11:0] STATUS_OFS = 12'h004;
	localparam logic [11:0] STRAP_OFS = 12'h008;
	localparam logic [11:0] PEND_OFS = 12'h00c;
	localparam int CTRL_CORE_DIS_LSB = 0;
	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam int STAT_HALTED_LSB = 13;
	localparam int STAT_RATIO_BIT = 15;
	localparam int STAT_VID_BIT = 16;

	// break event index
	localparam int EV_SMI = 0;
	localparam int EV_INIT = 1;
	localparam int EV_MASKABLE_INTERRUPT = 2;
	localparam int EV_NMI = 3;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [12:0] {
		ST_NORMAL = 13'h0001,
		ST_HALT = 13'h0002,
		ST_HALT_SNOOP = 13'h0004,
		ST_ACK = 13'h0008,
		ST_GRANT_WAIT = 13'h0010,
		ST_GRANT = 13'h0020,
		ST_GRANT_SNOOP = 13'h0040,
		ST_LOW_RATIO = 13'h0080,
		ST_LOW_VID = 13'h0100,
		ST_EXT = 13'h0200,
		ST_EXT_SNOOP = 13'h0400,
		ST_REST_VID = 13'h0800,
		ST_REST_RATIO = 13'h1000
	} sslp_state_t;

	typedef struct packed {
		logic agent_id;
		logic no_bus_parking;
		logic run_self_test;
		logic out_tristate;
	} sslp_strap_t;
endpackage

// *** hw/sslp_axil_slave.sv ***
/*
 sslp_axil_slave: axi4-lite slave front end, one write and one
 read at a time. assumes the owner decodes reg_waddr/reg_raddr
 combinationally and answers with reg_werr, reg_rdata, reg_rerr.
*/
`timescale 1ns/1ps
module sslp_axil_slave (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// register side
	output logic reg_wr,
	output logic [11:0] reg_waddr,
	output logic [31:0] reg_wdata,
	output logic [3:0] reg_wstrb,
	input wire logic reg_werr,
	output logic [11:0] reg_raddr,
	input wire logic [31:0] reg_rdata,
	input wire logic reg_rerr
);
	logic aw_full_q;
	logic w_full_q;
	logic [11:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	wire aw_take = s_axi_awvalid & ~aw_full_q;
	wire w_take = s_axi_wvalid & ~w_full_q;
	wire ar_take = s_axi_arvalid & ~rvalid_q;

	assign s_axi_awready = ~aw_full_q;
	assign s_axi_wready = ~w_full_q;
	assign s_axi_arready = ~rvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign reg_wr = aw_full_q & w_full_q & ~bvalid_q;
	assign reg_waddr = aw_addr_q;
	assign reg_wdata = w_data_q;
	assign reg_wstrb = w_strb_q;
	assign reg_raddr = s_axi_araddr;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			aw_addr_q <= 12'h000;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
		end else begin
			if (aw_take) begin
				aw_full_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end else if (reg_wr) begin
				aw_full_q <= 1'b0;
			end
			if (w_take) begin
				w_full_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end else if (reg_wr) begin
				w_full_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q <= 2'h0;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= 2'h0;
		end else begin
			if (reg_wr) begin
				bvalid_q <= 1'b1;
				bresp_q <= reg_werr ? sslp_pkg::RESP_SLVERR : sslp_pkg::RESP_OKAY;
			end else if (s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
			if (ar_take) begin
				rvalid_q <= 1'b1;
				rdata_q <= reg_rdata;
				rresp_q <= reg_rerr ? sslp_pkg::RESP_SLVERR : sslp_pkg::RESP_OKAY;
			end else if (s_axi_rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end
endmodule

// *** bench/sslp_top_properties.sv ***
/*
 sslp_properties: port-level checks of sslp_top.
 assumes one aclk domain; bound from the bench top file.
*/
`timescale 1ns/1ps
module sslp_properties (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// straps and events
	input wire logic system_mgmt_interrupt_n,
	input wire logic strap_self_test_select_n,
	input wire logic strap_no_bus_parking_n,
	input wire logic bus_request_zero_n,
	input wire sslp_pkg::sslp_strap_t strap_cfg,
	input wire logic core_init,
	input wire logic [1:0] local_interrupt_lines,
	input wire logic [3:0] event_service,
	// sequencer
	input wire logic stop_clock_request_n,
	input wire logic grant_ack_req,
	input wire logic grant_ack_resp,
	input wire logic snoop_start,
	input wire logic snoop_done,
	input wire logic snoop_state,
	input wire logic [6:0] vid_low,
	input wire logic [6:0] vid_nominal,
	input wire logic core_ratio_low,
	input wire logic [6:0] voltage_id_code,
	input wire sslp_pkg::sslp_state_t power_state
);
	logic [3:0] pins_n;

	assign pins_n = {bus_request_zero_n, strap_no_bus_parking_n,
		strap_self_test_select_n, system_mgmt_interrupt_n};

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_strap_capture: assert property (
		$rose(aresetn) |=> strap_cfg == ~$past(pins_n)) else $error("strap capture wrong");
	chk_init_pulse: assert property (
		$rose(aresetn) |=> core_init ##1 !core_init) else $error("init pulse wrong");
	chk_stop_ack: assert property (
		!stop_clock_request_n && (power_state == sslp_pkg::ST_NORMAL ||
		power_state == sslp_pkg::ST_HALT) |=> grant_ack_req) else $error("no ack cycle");
	chk_grant_delay: assert property (
		grant_ack_req && grant_ack_resp |-> ##20 power_state == sslp_pkg::ST_GRANT_WAIT
		##1 (power_state == sslp_pkg::ST_GRANT || power_state == sslp_pkg::ST_LOW_RATIO))
		else $error("grant delay wrong");
	chk_snoop_enter: assert property (
		snoop_start && (power_state == sslp_pkg::ST_HALT || power_state == sslp_pkg::ST_GRANT
		|| power_state == sslp_pkg::ST_EXT) |=> snoop_state) else $error("snoop missed");
	chk_snoop_return: assert property (
		snoop_state && snoop_done |=> power_state ==
		($past(power_state) == sslp_pkg::ST_HALT_SNOOP ? sslp_pkg::ST_HALT :
		$past(power_state) == sslp_pkg::ST_GRANT_SNOOP ? sslp_pkg::ST_GRANT : sslp_pkg::ST_EXT))
		else $error("snoop return wrong");
	chk_grant_quiet: assert property (
		power_state == sslp_pkg::ST_GRANT |-> event_service == 4'h0)
		else $error("event served in grant");
	chk_ext_vid: assert property (
		$changed(voltage_id_code) && voltage_id_code == vid_low
		|-> core_ratio_low && $past(core_ratio_low)) else $error("vid before ratio");
	chk_ext_restore: assert property (
		$fell(core_ratio_low) |-> voltage_id_code == vid_nominal
		&& $past(voltage_id_code) == vid_nominal) else $error("ratio before vid");
	chk_halt_wake: assert property (
		power_state == sslp_pkg::ST_HALT && $rose(local_interrupt_lines[1])
		|-> ##[1:3] power_state == sslp_pkg::ST_NORMAL) else $error("no wake");
endmodule

// *** bench/sslp_chipset_model.sv ***
/*
 sslp_chipset_model: system side of the stop-clock and snoop links.
 assumes the bench pulses snoop_go and sets model_delay.
*/
`timescale 1ns/1ps
module sslp_chipset_model (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// bench control
	input wire logic snoop_go,
	input wire logic [3:0] model_delay,
	// device side
	input wire logic grant_ack_req,
	output logic grant_ack_resp,
	output logic snoop_start,
	output logic snoop_done
);
	logic [3:0] ack_cnt_q;
	logic [3:0] snp_cnt_q;
	logic snp_busy_q;

	// bus inputs sit inactive outside these pulses
	always_ff @(posedge aclk) begin
		grant_ack_resp <= 1'b0;
		snoop_start <= 1'b0;
		snoop_done <= 1'b0;
		if (!aresetn) begin
			ack_cnt_q <= 4'h0;
			snp_cnt_q <= 4'h0;
			snp_busy_q <= 1'b0;
		end else begin
			if (grant_ack_req && !grant_ack_resp) begin
				ack_cnt_q <= ack_cnt_q + 4'h1;
				if (ack_cnt_q == model_delay) begin
					grant_ack_resp <= 1'b1;
					ack_cnt_q <= 4'h0;
				end
			end
			if (snoop_go && !snp_busy_q) begin
				snoop_start <= 1'b1;
				snp_busy_q <= 1'b1;
				snp_cnt_q <= 4'h0;
			end else if (snp_busy_q) begin
				snp_cnt_q <= snp_cnt_q + 4'h1;
				if (snp_cnt_q == model_delay) begin
					snoop_done <= 1'b1;
					snp_busy_q <= 1'b0;
				end
			end
		end
	end
endmodule

// *** bench/test_sslp_top.sv ***
/*
 test_sslp_top: self-checking bench for sslp_top.
 assumes the package, design, chipset model and checker compiled first.
*/
`timescale 1ns/1ps
`define CK(got, exp, msg) \
	cmp_count++; \
	if ((got) !== (exp)) begin \
		n_mismatch++; \
		$display("MISMATCH %0t %s", $time, msg); \
	end
module test_sslp_top;
	localparam logic [6:0] VID_NOM = 7'h30;
	localparam logic [6:0] VID_LO = 7'h18;
	int n_mismatch = 0, cmp_count = 0, cyc = 0;
	logic aclk = 1'b0, aresetn = 1'b0, snoop_go = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf, model_delay = 4'h3, event_service;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, init_request_n = 1'b1;
	logic system_mgmt_interrupt_n = 1'b1, strap_self_test_select_n = 1'b1;
	logic strap_no_bus_parking_n = 1'b1, bus_request_zero_n = 1'b1;
	logic stop_clock_request_n = 1'b1, ext_halt_en = 1'b0, ext_grant_en = 1'b0;
	logic [1:0] local_interrupt_lines = 2'h0, core_halt_exec = 2'h0;
	logic [6:0] vid_nominal = VID_NOM, vid_low = VID_LO, voltage_id_code;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, core_halted, core_disabled;
	logic core_init, grant_ack_req, grant_ack_resp, snoop_start, snoop_done;
	logic snoop_state, core_ratio_low;
	sslp_pkg::sslp_strap_t strap_cfg;
	sslp_pkg::sslp_state_t power_state;

	always #4 aclk = ~aclk;
	sslp_top u_dut (.*);
	sslp_chipset_model u_chipset (.*);

	always @(posedge aclk) begin
		cyc++;
		if (cyc == 5000) begin
			n_mismatch++;
			print_verdict();
		end
	end

	//----------------------------------------
	// bus and pin helpers
	//----------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask

	task automatic wait_st(input sslp_pkg::sslp_state_t s);
		int n = 0;
		while (power_state !== s && n < 1000) begin
			@(posedge aclk);
			n++;
		end
		`CK(power_state, s, "state")
	endtask

	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		`CK(s_axi_bresp, er, "bresp")
		tick(1);
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
		input logic [1:0] er);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		`CK(s_axi_rdata & m, e, "rdata")
		`CK(s_axi_rresp, er, "rresp")
		tick(1);
	endtask

	task automatic do_reset(input logic [3:0] p);
		{bus_request_zero_n, strap_no_bus_parking_n, strap_self_test_select_n,
			system_mgmt_interrupt_n} <= p;
		aresetn <= 1'b0;
		tick(12);
		aresetn <= 1'b1;
		tick(1);
		{bus_request_zero_n, strap_no_bus_parking_n, strap_self_test_select_n,
			system_mgmt_interrupt_n} <= 4'hf;
		tick(1);
		`CK(strap_cfg, ~p, "strap")
		`CK(core_init, 1'b1, "init")
		tick(3);
		`CK(strap_cfg, ~p, "strap held")
	endtask

	task automatic ev(input int b);
		if (b == 0) system_mgmt_interrupt_n <= 1'b0;
		if (b == 1) init_request_n <= 1'b0;
		if (b > 1) local_interrupt_lines[b-2] <= 1'b1;
		tick(2);
		system_mgmt_interrupt_n <= 1'b1;
		init_request_n <= 1'b1;
		local_interrupt_lines <= 2'h0;
		tick(2);
	endtask

	task automatic snoop(input sslp_pkg::sslp_state_t s, input sslp_pkg::sslp_state_t r);
		snoop_go <= 1'b1;
		tick(1);
		snoop_go <= 1'b0;
		wait_st(s);
		wait_st(r);
	endtask

	//----------------------------------------
	// scenarios
	//----------------------------------------
	task automatic t_regs;
		rd_chk(sslp_pkg::STRAP_OFS, 32'hf, 32'h5, sslp_pkg::RESP_OKAY);
		axi_wr(sslp_pkg::CTRL_OFS, 32'h1, sslp_pkg::RESP_OKAY);
		tick(1);
		`CK(core_disabled, 2'h1, "disable")
		axi_wr(sslp_pkg::CTRL_OFS, 32'h3, sslp_pkg::RESP_SLVERR);
		rd_chk(sslp_pkg::CTRL_OFS, 32'h3, 32'h1, sslp_pkg::RESP_OKAY);
		axi_wr(sslp_pkg::STATUS_OFS, 32'h1, sslp_pkg::RESP_OKAY);
		rd_chk(sslp_pkg::STATUS_OFS, 32'h1fff, 32'h1, sslp_pkg::RESP_OKAY);
		rd_chk(12'h010, 32'hffff_ffff, 32'h0, sslp_pkg::RESP_SLVERR);
		axi_wr(12'h010, 32'h0, sslp_pkg::RESP_SLVERR);
		axi_wr(sslp_pkg::CTRL_OFS, 32'h0, sslp_pkg::RESP_OKAY);
		$display("test regs done");
	endtask

	task automatic t_halt;
		core_halt_exec <= 2'h1;
		tick(1);
		core_halt_exec <= 2'h0;
		tick(3);
		`CK(core_halted, 2'h1, "one halted")
		`CK(power_state, sslp_pkg::ST_NORMAL, "pkg runs")
		core_halt_exec <= 2'h2;
		tick(1);
		core_halt_exec <= 2'h0;
		wait_st(sslp_pkg::ST_HALT);
		snoop(sslp_pkg::ST_HALT_SNOOP, sslp_pkg::ST_HALT);
		stop_clock_request_n <= 1'b0;
		wait_st(sslp_pkg::ST_GRANT);
		stop_clock_request_n <= 1'b1;
		tick(2);
		`CK(power_state, sslp_pkg::ST_HALT, "back to halt")
		ev(3);
		wait_st(sslp_pkg::ST_NORMAL);
		$display("test halt done");
	endtask

	task automatic t_ext(input logic grant);
		ext_halt_en <= !grant;
		ext_grant_en <= grant;
		if (grant) stop_clock_request_n <= 1'b0;
		else core_halt_exec <= 2'h3;
		tick(1);
		core_halt_exec <= 2'h0;
		wait_st(sslp_pkg::ST_LOW_RATIO);
		ext_halt_en <= 1'b0;
		ext_grant_en <= 1'b0;
		wait_st(sslp_pkg::ST_EXT);
		`CK({core_ratio_low, voltage_id_code}, {1'b1, VID_LO}, "low point")
		snoop(sslp_pkg::ST_EXT_SNOOP, sslp_pkg::ST_EXT);
		if (grant) stop_clock_request_n <= 1'b1;
		else ev(2);
		wait_st(sslp_pkg::ST_NORMAL);
		`CK({core_ratio_low, voltage_id_code}, {1'b0, VID_NOM}, "nominal")
		$display("test extended done");
	endtask

	task automatic t_grant;
		int n_svc[4] = '{0, 0, 0, 0};
		model_delay <= 4'h5;
		stop_clock_request_n <= 1'b0;
		wait_st(sslp_pkg::ST_GRANT);
		ev(0);
		ev(0);
		ev(1);
		ev(2);
		rd_chk(sslp_pkg::PEND_OFS, 32'hf, 32'h7, sslp_pkg::RESP_OKAY);
		snoop(sslp_pkg::ST_GRANT_SNOOP, sslp_pkg::ST_GRANT);
		stop_clock_request_n <= 1'b1;
		repeat (8) begin
			@(posedge aclk);
			for (int b = 0; b < 4; b++) n_svc[b] += int'(event_service[b] === 1'b1);
		end
		`CK({n_svc[0], n_svc[1], n_svc[2], n_svc[3]}, {32'd1, 32'd1, 32'd1, 32'd0}, "svc")
		stop_clock_request_n <= 1'b0;
		wait_st(sslp_pkg::ST_GRANT);
		do_reset(4'h5);
		`CK(power_state, sslp_pkg::ST_GRANT, "reset in grant")
		stop_clock_request_n <= 1'b1;
		tick(2);
		`CK(power_state, sslp_pkg::ST_NORMAL, "to normal")
		$display("test grant done");
	endtask

	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	initial begin
		do_reset(4'ha);
		t_regs();
		t_halt();
		t_ext(1'b0);
		t_grant();
		t_ext(1'b1);
		print_verdict();
	end
endmodule

bind sslp_top sslp_properties u_props (.*);
